// file: hw/dmacfg_defs.vh
// constants for the dma channel mode configuration block
`ifndef DMACFG_DEFS_VH
`define DMACFG_DEFS_VH

// io port addresses
`define DMACFG_LO_CMD_ADDR      16'h0008
`define DMACFG_HI_CMD_ADDR      16'h00d0
`define DMACFG_LO_MODE_ADDR     16'h000b
`define DMACFG_HI_MODE_ADDR     16'h00d6
`define DMACFG_LO_XMODE_ADDR    16'h040b
`define DMACFG_HI_XMODE_ADDR    16'h04d6
`define DMACFG_LO_CLEAR_ADDR    16'h000d
`define DMACFG_HI_CLEAR_ADDR    16'h00da

// command register fields
`define DMACFG_CMD_DIS_BIT      2

// mode register layout, stored bits 7:2 held as [5:0]
`define DMACFG_SEL_LSB          0
`define DMACFG_SEL_MSB          1
`define DMACFG_STORE_LSB        2
`define DMACFG_STORE_MSB        7
`define DMACFG_M_MODE_MSB       5
`define DMACFG_M_MODE_LSB       4
`define DMACFG_M_DEC_BIT        3
`define DMACFG_M_AUTO_BIT       2
`define DMACFG_M_TYPE_MSB       1
`define DMACFG_M_TYPE_LSB       0
`define DMACFG_MODE_RESET       6'h00
`define DMACFG_MODE_CH4_RESET   6'h30
`define DMACFG_MODE_CASCADE_CH  4

// transfer modes
`define DMACFG_XM_DEMAND        2'h0
`define DMACFG_XM_SINGLE        2'h1
`define DMACFG_XM_BLOCK         2'h2
`define DMACFG_XM_CASCADE       2'h3

// transfer types
`define DMACFG_TT_VERIFY        2'h0
`define DMACFG_TT_WRITE         2'h1
`define DMACFG_TT_READ          2'h2
`define DMACFG_TT_ILLEGAL       2'h3

// extended mode layout, stored bits 7:2 held as [5:0]
`define DMACFG_X_RSVD_BIT       5
`define DMACFG_X_EOPIN_BIT      4
`define DMACFG_X_TIM_MSB        3
`define DMACFG_X_TIM_LSB        2
`define DMACFG_X_SIZE_MSB       1
`define DMACFG_X_SIZE_LSB       0
`define DMACFG_XMODE_LO_RESET   6'h00
`define DMACFG_XMODE_HI_RESET   6'h01

// data sizes
`define DMACFG_SZ_8_BYTES       2'h0
`define DMACFG_SZ_16_WORDS      2'h1
`define DMACFG_SZ_RSVD          2'h2
`define DMACFG_SZ_16_BYTES      2'h3

// timing codes and bus clocks per cycle
`define DMACFG_TIM_COMPAT       2'h0
`define DMACFG_TIM_A            2'h1
`define DMACFG_TIM_B            2'h2
`define DMACFG_TIM_F            2'h3
`define DMACFG_CLK_COMPAT_ONE   4'h9
`define DMACFG_CLK_COMPAT_REP   4'h8
`define DMACFG_CLK_A            4'h6
`define DMACFG_CLK_B            4'h5
`define DMACFG_CLK_F            4'h3

`endif

// file: hw/dmacfg_cycle_timer.v
// dma cycle length timer counted in isa bus clocks
`timescale 1ns/10ps
`include "dmacfg_defs.vh"

module dmacfg_cycle_timer (
  input  wire       i_core_clk,
  input  wire       i_rst,
  input  wire       i_ce,
  input  wire       i_isa_bus_clock_tick,
  input  wire       i_start,
  input  wire       i_repeat,
  input  wire [1:0] i_timing,
  output reg        o_busy,
  output reg        o_done,
  output reg  [3:0] o_cycle_len
);

  reg [3:0] count;
  reg [3:0] next_len;

  function [3:0] dmacfg_len;
    input [1:0] timing;
    input       rep;
    begin
      case (timing)
        `DMACFG_TIM_COMPAT: dmacfg_len = rep ? `DMACFG_CLK_COMPAT_REP
                                             : `DMACFG_CLK_COMPAT_ONE;
        `DMACFG_TIM_A:      dmacfg_len = `DMACFG_CLK_A;
        `DMACFG_TIM_B:      dmacfg_len = `DMACFG_CLK_B;
        `DMACFG_TIM_F:      dmacfg_len = `DMACFG_CLK_F;
        default:            dmacfg_len = `DMACFG_CLK_COMPAT_ONE;
      endcase
    end
  endfunction

  always @* begin
    next_len = dmacfg_len(i_timing, i_repeat);
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      count       <= 4'h0;
      o_busy      <= 1'b0;
      o_done      <= 1'b0;
      o_cycle_len <= 4'h0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (!o_busy && i_start) begin
        o_busy      <= 1'b1;
        count       <= next_len;
        o_cycle_len <= next_len;
      end else if (o_busy && i_isa_bus_clock_tick) begin
        if (count == 4'h1) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        count <= count - 4'h1;
      end
    end
  end

endmodule

// file: hw/dmacfg_top.v
// dma channel mode, extended mode and group command configuration
`timescale 1ns/10ps
`include "dmacfg_defs.vh"


module dmacfg_top (
  input  wire        i_core_clk,
  input  wire        i_rst,
  input  wire        i_ce,
  input  wire [15:0] i_io_addr,
  input  wire [7:0]  i_io_wdata,
  input  wire        i_io_wr,
  input  wire [7:0]  i_dma_grant_ack,
  input  wire [7:0]  i_terminal_count,
  input  wire        i_isa_bus_clock_tick,
  input  wire        i_cycle_start,
  input  wire        i_cycle_repeat,
  input  wire        i_main_mem,
  input  wire        i_end_of_process_i,
  output reg         o_end_of_process_o,
  output reg         o_end_of_process_oe,
  output reg  [1:0]  o_group_disabled,
  output reg  [15:0] o_xfer_mode,
  output reg  [15:0] o_xfer_type,
  output reg  [7:0]  o_addr_down,
  output reg  [7:0]  o_autoinit,
  output reg  [15:0] o_data_size,
  output reg  [15:0] o_timing,
  output reg  [7:0]  o_eop_input,
  output reg  [7:0]  o_reload,
  output reg  [7:0]  o_eop_event,
  output reg         o_act_valid,
  output reg  [2:0]  o_act_channel,
  output reg         o_act_illegal,
  output reg         o_io_read_req,
  output reg         o_io_write_req,
  output reg         o_mem_read_req,
  output reg         o_mem_write_req,
  output reg  [1:0]  o_addr_step,
  output wire        o_cycle_busy,
  output wire        o_cycle_done,
  output wire [3:0]  o_cycle_len
);

  reg [5:0] mode_reg [0:7];
  reg [5:0] xmode_reg [0:7];
  reg       lo_disable;
  reg       hi_disable;
  reg [7:0] ack_prev;
  reg       eop_in_prev;
  reg [2:0] act_ch;
  reg       act_valid;
  reg [5:0] act_mode;
  reg [5:0] act_xmode;
  reg [1:0] act_type;
  reg [1:0] act_timing;
  reg       act_group_off;
  reg       next_io_rd;
  reg       next_io_wr;
  reg       next_mem_rd;
  reg       next_mem_wr;
  reg       next_eop_o;
  reg [7:0] next_event;
  integer   i;
  integer   j;
  integer   n;

  wire wr_lo_cmd   = i_io_wr && (i_io_addr == `DMACFG_LO_CMD_ADDR);
  wire wr_hi_cmd   = i_io_wr && (i_io_addr == `DMACFG_HI_CMD_ADDR);
  wire wr_lo_mode  = i_io_wr && (i_io_addr == `DMACFG_LO_MODE_ADDR);
  wire wr_hi_mode  = i_io_wr && (i_io_addr == `DMACFG_HI_MODE_ADDR);
  wire wr_lo_xmode = i_io_wr && (i_io_addr == `DMACFG_LO_XMODE_ADDR);
  wire wr_hi_xmode = i_io_wr && (i_io_addr == `DMACFG_HI_XMODE_ADDR);
  wire clr_lo      = i_io_wr && (i_io_addr == `DMACFG_LO_CLEAR_ADDR);
  wire clr_hi      = i_io_wr && (i_io_addr == `DMACFG_HI_CLEAR_ADDR);

  wire [1:0] wr_sel  = i_io_wdata[`DMACFG_SEL_MSB:`DMACFG_SEL_LSB];
  wire [5:0] wr_bits = i_io_wdata[`DMACFG_STORE_MSB:`DMACFG_STORE_LSB];

  // channel number from group and select code
  function [2:0] dmacfg_chan;
    input       upper;
    input [1:0] sel;
    begin
      dmacfg_chan = {upper, sel};
    end
  endfunction

  // channel 4 mode field is pinned to cascade
  function [5:0] dmacfg_mode_fix;
    input [2:0] ch;
    input [5:0] val;
    begin
      if (ch == `DMACFG_MODE_CASCADE_CH)
        dmacfg_mode_fix = {`DMACFG_XM_CASCADE, val[3:0]};
      else
        dmacfg_mode_fix = val;
    end
  endfunction

  // one-hot grant to channel number
  function [2:0] dmacfg_enc;
    input [7:0] onehot;
    integer k;
    begin
      dmacfg_enc = 3'h0;
      for (k = 0; k < 8; k = k + 1)
        if (onehot[k])
          dmacfg_enc = k[2:0];
    end
  endfunction

  // group command registers
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      lo_disable <= 1'b0;
      hi_disable <= 1'b0;
    end else if (i_ce) begin
      if (clr_lo)
        lo_disable <= 1'b0;
      else if (wr_lo_cmd)
        lo_disable <= i_io_wdata[`DMACFG_CMD_DIS_BIT];
      if (clr_hi)
        hi_disable <= 1'b0;
      else if (wr_hi_cmd)
        hi_disable <= i_io_wdata[`DMACFG_CMD_DIS_BIT];
    end
  end

  // channel mode registers
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      // channel 4 comes out of reset in cascade
      mode_reg[0] <= `DMACFG_MODE_RESET;
      mode_reg[1] <= `DMACFG_MODE_RESET;
      mode_reg[2] <= `DMACFG_MODE_RESET;
      mode_reg[3] <= `DMACFG_MODE_RESET;
      mode_reg[4] <= `DMACFG_MODE_CH4_RESET;
      mode_reg[5] <= `DMACFG_MODE_RESET;
      mode_reg[6] <= `DMACFG_MODE_RESET;
      mode_reg[7] <= `DMACFG_MODE_RESET;
    end else if (i_ce) begin
      for (j = 0; j < 4; j = j + 1) begin
        if (clr_lo)
          mode_reg[j] <= dmacfg_mode_fix(j[2:0], `DMACFG_MODE_RESET);
        if (clr_hi)
          mode_reg[j+4] <= dmacfg_mode_fix(j[2:0] + 3'h4, `DMACFG_MODE_RESET);
      end
      if (wr_lo_mode && !clr_lo)
        mode_reg[dmacfg_chan(1'b0, wr_sel)] <=
          dmacfg_mode_fix(dmacfg_chan(1'b0, wr_sel), wr_bits);
      if (wr_hi_mode && !clr_hi)
        mode_reg[dmacfg_chan(1'b1, wr_sel)] <=
          dmacfg_mode_fix(dmacfg_chan(1'b1, wr_sel), wr_bits);
    end
  end

  // extended mode registers, master clear leaves them alone
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      xmode_reg[0] <= `DMACFG_XMODE_LO_RESET;
      xmode_reg[1] <= `DMACFG_XMODE_LO_RESET;
      xmode_reg[2] <= `DMACFG_XMODE_LO_RESET;
      xmode_reg[3] <= `DMACFG_XMODE_LO_RESET;
      xmode_reg[4] <= `DMACFG_XMODE_HI_RESET;
      xmode_reg[5] <= `DMACFG_XMODE_HI_RESET;
      xmode_reg[6] <= `DMACFG_XMODE_HI_RESET;
      xmode_reg[7] <= `DMACFG_XMODE_HI_RESET;
    end else if (i_ce) begin
      if (wr_lo_xmode)
        xmode_reg[dmacfg_chan(1'b0, wr_sel)] <= wr_bits;
      if (wr_hi_xmode)
        xmode_reg[dmacfg_chan(1'b1, wr_sel)] <= wr_bits;
    end
  end

  // active channel and its decoded settings
  always @* begin
    act_valid     = |i_dma_grant_ack;
    act_ch        = dmacfg_enc(i_dma_grant_ack);
    act_mode      = mode_reg[act_ch];
    act_xmode     = xmode_reg[act_ch];
    act_group_off = hi_disable || (!act_ch[2] && lo_disable);
    if (act_mode[`DMACFG_M_MODE_MSB:`DMACFG_M_MODE_LSB] == `DMACFG_XM_CASCADE)
      act_type = `DMACFG_TT_VERIFY;
    else
      act_type = act_mode[`DMACFG_M_TYPE_MSB:`DMACFG_M_TYPE_LSB];
    if (i_main_mem)
      act_timing = act_xmode[`DMACFG_X_TIM_MSB:`DMACFG_X_TIM_LSB];
    else
      act_timing = `DMACFG_TIM_COMPAT;
  end

  // command strobe requests by transfer type
  always @* begin
    next_io_rd  = 1'b0;
    next_io_wr  = 1'b0;
    next_mem_rd = 1'b0;
    next_mem_wr = 1'b0;
    if (act_valid && !act_group_off && o_cycle_busy) begin
      case (act_type)
        `DMACFG_TT_WRITE: begin
          next_io_rd  = 1'b1;
          next_mem_wr = 1'b1;
        end
        `DMACFG_TT_READ: begin
          next_mem_rd = 1'b1;
          next_io_wr  = 1'b1;
        end
        `DMACFG_TT_VERIFY: begin
          next_io_rd  = 1'b0;
          next_mem_wr = 1'b0;
        end
        default: begin
          next_io_rd  = 1'b0;
          next_mem_wr = 1'b0;
        end
      endcase
    end
  end

  // end of process events, direction and drive value
  always @* begin
    next_event = i_terminal_count;
    if (act_valid && act_xmode[`DMACFG_X_EOPIN_BIT] &&
        i_end_of_process_i && !eop_in_prev)
      next_event[act_ch] = 1'b1;
    next_eop_o = act_valid && !act_xmode[`DMACFG_X_EOPIN_BIT] &&
                 (i_dma_grant_ack == ack_prev) &&
                 i_terminal_count[act_ch];
  end

  // upper disable also stops the cascaded lower group
  wire cycle_go = i_cycle_start && act_valid && !act_group_off;
  dmacfg_cycle_timer u_timer (
    .i_core_clk           (i_core_clk),
    .i_rst                (i_rst),
    .i_ce                 (i_ce),
    .i_isa_bus_clock_tick (i_isa_bus_clock_tick),
    .i_start              (cycle_go),
    .i_repeat             (i_cycle_repeat),
    .i_timing             (act_timing),
    .o_busy               (o_cycle_busy),
    .o_done               (o_cycle_done),
    .o_cycle_len          (o_cycle_len)
  );

  // per-channel register copies
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_group_disabled    <= 2'h0;
      o_xfer_mode         <= 16'h0000;
      o_xfer_type         <= 16'h0000;
      o_addr_down         <= 8'h00;
      o_autoinit          <= 8'h00;
      o_data_size         <= 16'h0000;
      o_timing            <= 16'h0000;
      o_eop_input         <= 8'h00;
    end else if (i_ce) begin
      o_group_disabled <= {hi_disable, hi_disable | lo_disable};
      for (i = 0; i < 8; i = i + 1) begin
        o_xfer_mode[2*i +: 2] <=
          mode_reg[i][`DMACFG_M_MODE_MSB:`DMACFG_M_MODE_LSB];
        o_xfer_type[2*i +: 2] <=
          mode_reg[i][`DMACFG_M_TYPE_MSB:`DMACFG_M_TYPE_LSB];
        o_addr_down[i] <= mode_reg[i][`DMACFG_M_DEC_BIT];
        o_autoinit[i]  <= mode_reg[i][`DMACFG_M_AUTO_BIT];
        o_data_size[2*i +: 2] <=
          xmode_reg[i][`DMACFG_X_SIZE_MSB:`DMACFG_X_SIZE_LSB];
        o_timing[2*i +: 2] <=
          xmode_reg[i][`DMACFG_X_TIM_MSB:`DMACFG_X_TIM_LSB];
        o_eop_input[i] <= xmode_reg[i][`DMACFG_X_EOPIN_BIT];
      end
    end
  end

  // active channel outputs
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_end_of_process_o  <= 1'b0;
      o_end_of_process_oe <= 1'b0;
      o_reload            <= 8'h00;
      o_eop_event         <= 8'h00;
      o_act_valid         <= 1'b0;
      o_act_channel       <= 3'h0;
      o_act_illegal       <= 1'b0;
      o_io_read_req       <= 1'b0;
      o_io_write_req      <= 1'b0;
      o_mem_read_req      <= 1'b0;
      o_mem_write_req     <= 1'b0;
      o_addr_step         <= 2'h0;
      ack_prev            <= 8'h00;
      eop_in_prev         <= 1'b0;
    end else if (i_ce) begin
      ack_prev    <= i_dma_grant_ack;
      eop_in_prev <= i_end_of_process_i;
      for (n = 0; n < 8; n = n + 1) begin
        o_reload[n] <= next_event[n] && mode_reg[n][`DMACFG_M_AUTO_BIT];
      end
      o_eop_event   <= next_event;
      o_act_valid   <= act_valid;
      o_act_channel <= act_ch;
      o_act_illegal <= act_valid && (act_type == `DMACFG_TT_ILLEGAL);
      o_io_read_req   <= next_io_rd;
      o_io_write_req  <= next_io_wr;
      o_mem_read_req  <= next_mem_rd;
      o_mem_write_req <= next_mem_wr;
      // step two for 16-bit byte counting, else one
      if (act_xmode[`DMACFG_X_SIZE_MSB:`DMACFG_X_SIZE_LSB] == `DMACFG_SZ_16_BYTES)
        o_addr_step <= 2'h2;
      else
        o_addr_step <= 2'h1;
      o_end_of_process_oe <= act_valid && !act_xmode[`DMACFG_X_EOPIN_BIT];
      o_end_of_process_o  <= next_eop_o;
    end
  end

endmodule

// file: tb/dmacfg_checker_assertions.sv
// concurrent checks on the dma mode configuration block ports
`timescale 1ns/10ps
`include "dmacfg_defs.vh"
module dmacfg_checker (
  input wire        i_core_clk,
  input wire        i_rst,
  input wire        i_ce,
  input wire [15:0] i_io_addr,
  input wire [7:0]  i_io_wdata,
  input wire        i_io_wr,
  input wire [7:0]  i_dma_grant_ack,
  input wire        i_isa_bus_clock_tick,
  input wire        i_cycle_repeat,
  input wire        i_main_mem,
  input wire        o_end_of_process_o,
  input wire [1:0]  o_group_disabled,
  input wire [15:0] o_xfer_mode,
  input wire [7:0]  o_addr_down,
  input wire [15:0] o_data_size,
  input wire [15:0] o_timing,
  input wire [7:0]  o_eop_input,
  input wire        o_cycle_busy,
  input wire        o_cycle_done,
  input wire [3:0]  o_cycle_len
);
  wire      wr    = i_ce && i_io_wr;
  wire      m_lo2 = wr && i_io_addr == `DMACFG_LO_MODE_ADDR && i_io_wdata[1:0] == 2'h2;
  wire      c_lo  = wr && i_io_addr == `DMACFG_LO_CLEAR_ADDR;
  wire      x_hi3 = wr && i_io_addr == `DMACFG_HI_XMODE_ADDR && i_io_wdata[1:0] == 2'h3;
  wire      k_hi  = wr && i_io_addr == `DMACFG_HI_CMD_ADDR;
  reg [3:0] ticks;
  // bus clocks seen while a cycle runs
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ticks <= 4'h0;
    end else if (!o_cycle_busy) begin
      ticks <= 4'h0;
    end else if (i_ce && i_isa_bus_clock_tick) begin
      ticks <= ticks + 4'h1;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_ch4_cascade: assert property (!$past(i_rst) |-> o_xfer_mode[9:8] == 2'h3)
    else $error("channel 4 left cascade mode");
  a_mode_store: assert property ($past(m_lo2, 2) |->
    o_xfer_mode[5:4] == $past(i_io_wdata[7:6], 2) && o_addr_down[2] == $past(i_io_wdata[5], 2))
    else $error("mode write to channel 2 not stored");
  a_clear_mode: assert property ($past(c_lo, 2) |->
    o_xfer_mode[7:0] == 8'h00 && o_addr_down[3:0] == 4'h0)
    else $error("master clear left lower mode fields set");
  a_clear_keeps_ext: assert property ($past(c_lo, 2) |->
    $stable(o_data_size) && $stable(o_timing) && $stable(o_eop_input))
    else $error("master clear changed extended mode");
  a_ext_store: assert property ($past(x_hi3, 2) |->
    o_timing[15:14] == $past(i_io_wdata[5:4], 2) && o_eop_input[7] == $past(i_io_wdata[6], 2)
    && o_data_size[15:14] == $past(i_io_wdata[3:2], 2))
    else $error("extended write to channel 7 not stored");
  a_cmd_disable: assert property ($past(k_hi, 2) |->
    o_group_disabled[1] == $past(i_io_wdata[2], 2))
    else $error("upper group disable does not follow bit 2");
  a_upper_lower: assert property (o_group_disabled[1] |-> o_group_disabled[0])
    else $error("upper disabled but lower enabled");
  a_isa_compat: assert property ($rose(o_cycle_busy) && !$past(i_main_mem) |->
    o_cycle_len == ($past(i_cycle_repeat) ? 4'h8 : 4'h9))
    else $error("isa memory cycle not compatible length");
  a_done_count: assert property (o_cycle_done |-> ticks == o_cycle_len)
    else $error("cycle ended after wrong bus clock count");
  a_eop_switch: assert property (
    $past(i_dma_grant_ack) != $past(i_dma_grant_ack, 2) |-> !o_end_of_process_o)
    else $error("eop driven active while grant changed");
  c_cycle: cover property ($rose(o_cycle_done));
  c_eop: cover property (o_end_of_process_o);
  c_clear: cover property (c_lo);
endmodule

bind dmacfg_top dmacfg_checker u_checker (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce), .i_io_addr(i_io_addr),
  .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr), .i_dma_grant_ack(i_dma_grant_ack),
  .i_isa_bus_clock_tick(i_isa_bus_clock_tick), .i_cycle_repeat(i_cycle_repeat),
  .i_main_mem(i_main_mem), .o_end_of_process_o(o_end_of_process_o),
  .o_group_disabled(o_group_disabled), .o_xfer_mode(o_xfer_mode), .o_addr_down(o_addr_down),
  .o_data_size(o_data_size), .o_timing(o_timing), .o_eop_input(o_eop_input),
  .o_cycle_busy(o_cycle_busy), .o_cycle_done(o_cycle_done), .o_cycle_len(o_cycle_len)
);

// file: tb/dmacfg_slave_model.sv
// isa dma slave answering on the end-of-process line
`timescale 1ns/10ps
module dmacfg_slave_model (
  input  wire       i_core_clk,
  input  wire [7:0] i_dma_grant_ack,
  input  wire       i_dev_oe,
  input  wire       i_dev_eop,
  input  wire       i_fire,
  output wire       o_eop_line
);
  reg drive_hi = 1'b0;
  // active only once granted and the device output has floated
  always @(posedge i_core_clk) begin
    drive_hi <= i_fire && (|i_dma_grant_ack) && !i_dev_oe;
  end
  // pull-down keeps the line inactive low when nobody drives high
  assign o_eop_line = (i_dev_oe && i_dev_eop) || drive_hi;
endmodule

// file: tb/tb_dma_channel_mode_config.sv
// self-checking bench for the dma mode configuration block
`timescale 1ns/10ps
`include "dmacfg_defs.vh"
module tb_dma_channel_mode_config;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [15:0] addr = 16'h0000;
  reg  [7:0]  wdat = 8'h00;
  reg         wr = 1'b0;
  reg  [7:0]  gnt = 8'h00;
  reg  [7:0]  tc = 8'h00;
  reg         tick = 1'b0;
  reg         start = 1'b0;
  reg         rpt = 1'b0;
  reg         mm = 1'b1;
  reg         fire = 1'b0;
  reg         ce = 1'b1;
  wire        eop_line, eop_o, eop_oe, busy, done, rd_io, wr_io, rd_mem, wr_mem, av, ill;
  wire [1:0]  gdis, step;
  wire [2:0]  ach;
  wire [15:0] xmode, xtype, dsize, tim;
  wire [7:0]  down, ainit, eopin, reload, evt;
  wire [3:0]  len;
  integer     miscompares = 0;
  integer     num_checks = 0;
  always #10 clk = ~clk;
  always @(posedge clk) tick <= ~tick;
  dmacfg_top dut (
    .i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_io_addr(addr), .i_io_wdata(wdat),
    .i_io_wr(wr), .i_dma_grant_ack(gnt), .i_terminal_count(tc), .i_isa_bus_clock_tick(tick),
    .i_cycle_start(start), .i_cycle_repeat(rpt), .i_main_mem(mm), .i_end_of_process_i(eop_line),
    .o_end_of_process_o(eop_o), .o_end_of_process_oe(eop_oe), .o_group_disabled(gdis),
    .o_xfer_mode(xmode), .o_xfer_type(xtype), .o_addr_down(down), .o_autoinit(ainit),
    .o_data_size(dsize), .o_timing(tim), .o_eop_input(eopin), .o_reload(reload),
    .o_eop_event(evt), .o_act_valid(av), .o_act_channel(ach), .o_act_illegal(ill),
    .o_io_read_req(rd_io), .o_io_write_req(wr_io), .o_mem_read_req(rd_mem),
    .o_mem_write_req(wr_mem), .o_addr_step(step), .o_cycle_busy(busy), .o_cycle_done(done),
    .o_cycle_len(len)
  );
  dmacfg_slave_model slave (
    .i_core_clk(clk), .i_dma_grant_ack(gnt), .i_dev_oe(eop_oe), .i_dev_eop(eop_o),
    .i_fire(fire), .o_eop_line(eop_line)
  );
  task complete_run;
    begin
      if (miscompares == 0 && num_checks > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task io_wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
      #1;
    end
  endtask
  task t_defaults;
    begin
      @(posedge clk);
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(xmode, 16'h0300);
      chk(xtype | {8'h00, down} | {8'h00, ainit}, 16'h0000);
      chk(dsize, 16'h5500);
      chk(tim | {8'h00, eopin}, 16'h0000);
      chk({14'h0000, gdis}, 16'h0000);
    end
  endtask
  task t_mode;
    integer    n;
    reg [15:0] a, em, et;
    reg [7:0]  ed, ea;
    begin
      for (n = 0; n < 8; n = n + 1) begin
        a = (n < 4) ? `DMACFG_LO_MODE_ADDR : `DMACFG_HI_MODE_ADDR;
        io_wr(a, {n[1:0], n[0], n[1], ~n[1:0], n[1:0]});
        em[2*n +: 2] = (n == 4) ? 2'h3 : n[1:0];
        et[2*n +: 2] = ~n[1:0];
        ed[n] = n[0];
        ea[n] = n[1];
      end
      chk(xmode, em);
      chk(xtype, et);
      chk({ea, ed}, {ainit, down});
    end
  endtask
  task t_ext;
    integer    n;
    reg [15:0] a, es, et;
    reg [7:0]  ei;
    reg [1:0]  sz;
    begin
      for (n = 0; n < 8; n = n + 1) begin
        a = (n < 4) ? `DMACFG_LO_XMODE_ADDR : `DMACFG_HI_XMODE_ADDR;
        sz = n[0] ? 2'h3 : {1'b0, n[1]};
        io_wr(a, {1'b0, n[0] ^ n[2], n[2:1], sz, n[1:0]});
        es[2*n +: 2] = sz;
        et[2*n +: 2] = n[2:1];
        ei[n] = n[0] ^ n[2];
      end
      chk(dsize, es);
      chk(tim, et);
      chk({8'h00, eopin}, {8'h00, ei});
      io_wr(`DMACFG_LO_CLEAR_ADDR, 8'h00);
      io_wr(`DMACFG_HI_CLEAR_ADDR, 8'h00);
      chk(xmode | xtype, 16'h0300);
      chk({ainit, down}, 16'h0000);
      chk(dsize, es);
      chk(tim, et);
    end
  endtask
  task t_cmd;
    begin
      @(posedge clk);
      ce <= 1'b0;
      io_wr(`DMACFG_HI_CMD_ADDR, 8'h04);
      @(posedge clk);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk({14'h0000, gdis}, 16'h0000);
      io_wr(`DMACFG_LO_CMD_ADDR, 8'h04);
      chk({14'h0000, gdis}, 16'h0001);
      io_wr(`DMACFG_HI_CMD_ADDR, 8'h04);
      io_wr(`DMACFG_LO_CMD_ADDR, 8'h00);
      chk({14'h0000, gdis}, 16'h0003);
      io_wr(`DMACFG_HI_CMD_ADDR, 8'h00);
      chk({14'h0000, gdis}, 16'h0000);
    end
  endtask
  task run_cyc(input [1:0] tm, input [1:0] tp, input m, input r);
    integer   k;
    reg [3:0] n;
    begin
      n = (!m || tm == 2'h0) ? (r ? 4'h8 : 4'h9) :
          (tm == 2'h1 ? 4'h6 : (tm == 2'h2 ? 4'h5 : 4'h3));
      io_wr(`DMACFG_LO_XMODE_ADDR, {2'b00, tm, tp[0], tp[0], 2'h1});
      io_wr(`DMACFG_LO_MODE_ADDR, {4'h8, tp, 2'h1});
      @(posedge clk);
      gnt <= 8'h02;
      mm <= m;
      rpt <= r;
      start <= 1'b1;
      for (k = 0; k < 20 && busy !== 1'b1; k = k + 1) @(posedge clk) #1;
      @(posedge clk);
      start <= 1'b0;
      #1;
      chk({12'h000, rd_io, wr_io, rd_mem, wr_mem},
          tp == 2'h1 ? 16'h0009 : (tp == 2'h2 ? 16'h0006 : 16'h0000));
      chk({9'h000, av, ach, ill, step},
          {9'h000, 1'b1, 3'h1, tp == 2'h3, tp[0] ? 2'h2 : 2'h1});
      for (k = 0; k < 100 && done !== 1'b1; k = k + 1) @(posedge clk) #1;
      chk({11'h000, done, len}, {11'h001, n});
      @(posedge clk);
      gnt <= 8'h00;
    end
  endtask
  task t_cycle;
    begin
      run_cyc(2'h0, 2'h1, 1'b1, 1'b0);
      run_cyc(2'h0, 2'h2, 1'b1, 1'b1);
      run_cyc(2'h1, 2'h0, 1'b1, 1'b1);
      run_cyc(2'h2, 2'h1, 1'b1, 1'b1);
      run_cyc(2'h3, 2'h2, 1'b1, 1'b1);
      run_cyc(2'h1, 2'h3, 1'b1, 1'b0);
      run_cyc(2'h3, 2'h0, 1'b0, 1'b1);
      io_wr(`DMACFG_HI_CMD_ADDR, 8'h04);
      @(posedge clk);
      gnt <= 8'h02;
      start <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      chk({15'h0000, busy}, 16'h0000);
      @(posedge clk);
      start <= 1'b0;
      gnt <= 8'h00;
      io_wr(`DMACFG_HI_CMD_ADDR, 8'h00);
    end
  endtask
  task t_eop;
    reg seen;
    begin
      io_wr(`DMACFG_LO_XMODE_ADDR, 8'h02);
      io_wr(`DMACFG_LO_XMODE_ADDR, 8'h41);
      io_wr(`DMACFG_LO_MODE_ADDR, 8'h92);
      @(posedge clk);
      gnt <= 8'h04;
      repeat (2) @(posedge clk);
      tc <= 8'h04;
      @(posedge clk);
      tc <= 8'h00;
      #1;
      chk({13'h0000, eop_oe, eop_o, reload[2]}, 16'h0007);
      @(posedge clk);
      gnt <= 8'h02;
      repeat (2) @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      seen = 1'b0;
      repeat (6) begin
        @(posedge clk);
        #1;
        seen = seen | evt[1];
      end
      chk({14'h0000, seen, eop_oe}, 16'h0002);
      @(posedge clk);
      gnt <= 8'h00;
    end
  endtask
  initial begin
    t_defaults;
    t_mode;
    t_ext;
    t_cmd;
    t_cycle;
    t_eop;
    t_defaults;
    complete_run;
  end
  // generous span over the whole sequence
  initial begin
    #400000;
    miscompares = miscompares + 1;
    complete_run;
  end
endmodule
